// ---- logic/fault_unit_map.vh ----
/*
 Fault record constants for the protection and structural fault unit.
 Assumes inclusion by bare name from design files under logic/.
*/
`ifndef FAULT_UNIT_MAP_VH
`define FAULT_UNIT_MAP_VH

// Fault type codes
`define FTYPE_PROTECTION 8'h07
`define FTYPE_STRUCTURAL 8'h09
// Protection subtype bit positions
`define SUB_SEG_LENGTH_BIT 1
`define SUB_PAGE_RIGHTS_BIT 2
// Structural subtype codes
`define SUB_CONTROL 8'h01
`define SUB_DISPATCH 8'h02
`define SUB_IPMSG 8'h03
// Fault data field positions
`define PAGE_FIELD_LSB 12
`define SEL_FIELD_LSB 5
// Reset value of record words
`define RECORD_RESET 32'h0000_0000
// Record handshake: cycles from detect to record valid
`define RECORD_LATENCY 1

`endif

// ---- logic/fault_classify.v ----
/*
 Fault classifier: turns raw protection and structural conditions into a
 type code, subtype byte and flags, with a fixed priority.
 Assumes all inputs are valid in the same clock cycle.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fault_unit_map.vh"

module fault_classify (
   input wire operand_out_of_bounds,
   input wire selector_too_large,
   input wire page_rights_denied,
   input wire access_write,
   input wire ctrl_structure_bad,
   input wire fault_in_handler_call,
   input wire dispatch_structure_bad,
   input wire ipmsg_structure_bad,
   output reg any_fault,
   output reg is_protection,
   output reg seg_length,
   output reg [7:0] fault_type,
   output reg [7:0] fault_subtype,
   output reg write_access_flag,
   output reg second_fault_flag
);

   // Structural faults win: they leave the process state unusable anyway
   always @* begin
      seg_length = operand_out_of_bounds | selector_too_large;
      any_fault = 1'b0;
      is_protection = 1'b0;
      fault_type = 8'h00;
      fault_subtype = 8'h00;
      write_access_flag = 1'b0;
      second_fault_flag = 1'b0;
      if (ctrl_structure_bad | fault_in_handler_call) begin
         any_fault = 1'b1;
         fault_type = `FTYPE_STRUCTURAL;
         fault_subtype = `SUB_CONTROL;
      end else if (dispatch_structure_bad) begin
         any_fault = 1'b1;
         fault_type = `FTYPE_STRUCTURAL;
         fault_subtype = `SUB_DISPATCH;
      end else if (ipmsg_structure_bad) begin
         any_fault = 1'b1;
         fault_type = `FTYPE_STRUCTURAL;
         fault_subtype = `SUB_IPMSG;
      end else if (seg_length | page_rights_denied) begin
         any_fault = 1'b1;
         is_protection = 1'b1;
         fault_type = `FTYPE_PROTECTION;
         // Both bits may be set together
         fault_subtype[`SUB_SEG_LENGTH_BIT] = seg_length;
         fault_subtype[`SUB_PAGE_RIGHTS_BIT] = page_rights_denied;
         write_access_flag = page_rights_denied & access_write;
      end
   end

endmodule // fault_classify

`default_nettype wire

// ---- logic/protection_structural_fault_unit.v ----
/*
 Protection and structural fault unit: detects violations and latches the
 fault record read by the fault handler.
 Assumes the pipeline supplies checks, addresses and instruction pointers
 synchronous to clk, and holds fault_ack until the record is taken.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fault_unit_map.vh"

// Function
// - Protection fault uses type 7; subtype bit 1 segment length, bit 2 page rights.
// - Simultaneous segment-length and page-rights violations set both subtype bits.
// - Operand outside region bounds raises a segment-length fault.
// - Selector beyond last segment table entry raises a segment-length fault.
// - Paged access lacking rights for current mode raises a page-rights fault.
// - Write-access flag set for write, clear for read; second flag unused. The unit sets the flag on page-rights faults only.
// - Upper 20 faulting address bits go to bits 12..31 of data word 0.
// - The two top bits of the stored address are forced to zero.
// - Region selector goes to bits 5..31 of data word 1.
// - Out-of-bounds segment-length fault records the page in the same layout.
// - Oversized selector fault places the selector in data word 1.
// - Protection faults record faulting IP and copy it to saved IP.
// - Protection faults save state allowing re-execution or completion.
// - Instruction is aborted or suspended with partial state, per instruction.
// - Structural faults use type 9; codes 1 control, 2 dispatch, 3 message.
// - Control fault on bad structures blocking fault or interrupt service.
// - Dispatch fault when bad structures block process dispatch.
// - Message fault when bad structures block interprocessor message.
// - Structural faults may come from implicit operations without an instruction.
// - Structural faults leave flags, data and saved IP unused; record IP only.
// - After a structural fault the process state is undefined.
module protection_structural_fault_unit #(
   parameter ADDR_WIDTH = 32,
   parameter SEL_WIDTH = 27
) (
   input wire clk,
   input wire reset,
   input wire check_valid,
   input wire operand_out_of_bounds,
   input wire selector_too_large,
   input wire page_rights_denied,
   input wire access_write,
   input wire [ADDR_WIDTH-1:0] fault_address,
   input wire [SEL_WIDTH-1:0] region_selector,
   input wire [SEL_WIDTH-1:0] used_selector,
   input wire [31:0] instr_ip,
   input wire implicit_op,
   input wire ctrl_structure_bad,
   input wire fault_in_handler_call,
   input wire dispatch_structure_bad,
   input wire ipmsg_structure_bad,
   input wire suspendable_instr,
   input wire [31:0] partial_state,
   input wire fault_ack,
   output reg fault_valid,
   output reg [7:0] fault_type,
   output reg [7:0] fault_subtype,
   output reg write_access_flag,
   output reg second_fault_flag,
   output reg [31:0] fault_data0,
   output reg [31:0] fault_data1,
   output reg [31:0] faulting_ip,
   output reg [31:0] saved_ip,
   output reg instr_abort,
   output reg instr_suspend,
   output reg [31:0] resumption_state,
   output reg resumable,
   output reg state_undefined
);

   // Record handshake states
   localparam S_IDLE = 1'b0;
   localparam S_HELD = 1'b1;

   // Subtype bits each fault class may use; all other bits are reserved
   localparam [7:0] PROT_SUB_MASK =
      (8'h01 << `SUB_SEG_LENGTH_BIT) | (8'h01 << `SUB_PAGE_RIGHTS_BIT);
   localparam [7:0] STRUCT_SUB_MASK = 8'h03; // Codes 1 to 3 fit the two low bits

   reg state;
   wire gated_bounds;
   wire gated_selector;
   wire gated_rights;
   wire any_fault;
   wire is_protection;
   wire seg_length;
   wire [7:0] cls_type;
   wire [7:0] cls_subtype;
   wire cls_write;
   wire cls_second;
   wire take;
   wire prot_take;
   wire struct_take;
   wire [7:0] sub_mask;
   wire [7:0] sub_clean;
   reg [31:0] next_data0;
   reg [31:0] next_data1;
   reg [31:0] next_fault_ip;

   // Data word 0: upper address bits in the page field, top two bits cleared
   function [31:0] page_layout;
      input [ADDR_WIDTH-1:0] addr;
      begin
         page_layout = `RECORD_RESET;
         page_layout[31:`PAGE_FIELD_LSB] = addr[ADDR_WIDTH-1:ADDR_WIDTH-20];
         page_layout[31:30] = 2'b00;
      end
   endfunction

   // Data word 1: a segment selector in the selector field, low bits zero
   function [31:0] selector_layout;
      input [SEL_WIDTH-1:0] sel;
      begin
         selector_layout = `RECORD_RESET;
         selector_layout[31:`SEL_FIELD_LSB] = sel;
      end
   endfunction

   // Protection checks count only in a cycle the pipeline marks valid
   assign gated_bounds = check_valid & operand_out_of_bounds;
   assign gated_selector = check_valid & selector_too_large;
   assign gated_rights = check_valid & page_rights_denied;

   fault_classify u_classify (
      .operand_out_of_bounds(gated_bounds),
      .selector_too_large(gated_selector),
      .page_rights_denied(gated_rights),
      .access_write(access_write),
      .ctrl_structure_bad(ctrl_structure_bad),
      .fault_in_handler_call(fault_in_handler_call),
      .dispatch_structure_bad(dispatch_structure_bad),
      .ipmsg_structure_bad(ipmsg_structure_bad),
      .any_fault(any_fault),
      .is_protection(is_protection),
      .seg_length(seg_length),
      .fault_type(cls_type),
      .fault_subtype(cls_subtype),
      .write_access_flag(cls_write),
      .second_fault_flag(cls_second)
   );

   // Reserved subtype bits outside the class mask are scrubbed to zero, bit by bit
   assign sub_mask = is_protection ? PROT_SUB_MASK : STRUCT_SUB_MASK;
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_sub_scrub
         assign sub_clean[i] = cls_subtype[i] & sub_mask[i];
      end
   endgenerate

   // A new fault is taken only while no record is held
   assign take = (state == S_IDLE) & any_fault;
   assign prot_take = take & is_protection;
   assign struct_take = take & ~is_protection;

   // Fault data words for protection faults; structural faults leave them zero
   always @* begin
      next_data0 = `RECORD_RESET;
      next_data1 = `RECORD_RESET;
      if (is_protection) begin
         if (gated_rights | gated_bounds) begin
            next_data0 = page_layout(fault_address);
            next_data1 = selector_layout(region_selector);
         end else if (seg_length) begin
            next_data1 = selector_layout(used_selector);
         end
      end
   end

   // Implicit operations belong to no instruction, so their IP reads as zero in a structural record
   always @* begin
      next_fault_ip = instr_ip;
      if (implicit_op) begin
         next_fault_ip = `RECORD_RESET;
      end
   end

   // Record handshake: valid from the take edge up to the acknowledge edge
   always @(posedge clk) begin
      if (reset) begin
         state <= S_IDLE;
         fault_valid <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (take) begin
                  state <= S_HELD;
                  fault_valid <= 1'b1;
               end
            end
            S_HELD: begin
               if (fault_ack) begin
                  state <= S_IDLE;
                  fault_valid <= 1'b0;
               end
            end
            default: begin
               state <= S_IDLE;
               fault_valid <= 1'b0;
            end
         endcase
      end
   end

   // Type and subtype, captured only on a take so a held record never changes
   always @(posedge clk) begin
      if (reset) begin
         fault_type <= 8'h00;
         fault_subtype <= 8'h00;
      end else if (take) begin
         fault_type <= cls_type;
         fault_subtype <= sub_clean;
      end
   end

   // Flags belong to page-rights faults; a structural record clears them
   always @(posedge clk) begin
      if (reset) begin
         write_access_flag <= 1'b0;
         second_fault_flag <= 1'b0;
      end else if (prot_take) begin
         write_access_flag <= cls_write;
         second_fault_flag <= cls_second;
      end else if (struct_take) begin
         write_access_flag <= 1'b0;
         second_fault_flag <= 1'b0;
      end
   end

   // Data word 0; the next value is already zero for a structural fault
   always @(posedge clk) begin
      if (reset) begin
         fault_data0 <= `RECORD_RESET;
      end else if (take) begin
         fault_data0 <= next_data0;
      end
   end

   // Data word 1, taken on the same edge as word 0
   always @(posedge clk) begin
      if (reset) begin
         fault_data1 <= `RECORD_RESET;
      end else if (take) begin
         fault_data1 <= next_data1;
      end
   end

   // Faulting instruction pointer, recorded for both fault classes
   always @(posedge clk) begin
      if (reset) begin
         faulting_ip <= `RECORD_RESET;
      end else if (prot_take) begin
         faulting_ip <= instr_ip;
      end else if (struct_take) begin
         faulting_ip <= next_fault_ip;
      end
   end

   // Saved pointer copies the faulting one for protection, unused for structural
   always @(posedge clk) begin
      if (reset) begin
         saved_ip <= `RECORD_RESET;
      end else if (prot_take) begin
         saved_ip <= instr_ip;
      end else if (struct_take) begin
         saved_ip <= `RECORD_RESET;
      end
   end

   // One-cycle abort or suspend pulse; the instruction kind picks which for protection, structural faults always abort
   always @(posedge clk) begin
      if (reset) begin
         instr_abort <= 1'b0;
         instr_suspend <= 1'b0;
      end else begin
         instr_abort <= 1'b0;
         instr_suspend <= 1'b0;
         if (prot_take) begin
            instr_abort <= ~suspendable_instr;
            instr_suspend <= suspendable_instr;
         end else if (struct_take) begin
            instr_abort <= 1'b1;
         end
      end
   end

   // Resumption record and process-state status for the handler's return
   always @(posedge clk) begin
      if (reset) begin
         resumption_state <= `RECORD_RESET;
         resumable <= 1'b0;
         state_undefined <= 1'b0;
      end else if (prot_take) begin
         resumption_state <= suspendable_instr ? partial_state : `RECORD_RESET;
         resumable <= 1'b1;
         state_undefined <= 1'b0;
      end else if (struct_take) begin
         resumption_state <= `RECORD_RESET;
         resumable <= 1'b0;
         state_undefined <= 1'b1;
      end
   end

endmodule // protection_structural_fault_unit

`default_nettype wire

// ---- sim/protection_structural_fault_unit_sva.sv ----
/*
 Checker for the protection and structural fault unit.
 Assumes the unit's port names; bound to every instance of the unit.
*/
`timescale 1ns/1ns
`default_nettype none
module protection_structural_fault_unit_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic check_valid,
   input wire logic operand_out_of_bounds,
   input wire logic selector_too_large,
   input wire logic page_rights_denied,
   input wire logic ctrl_structure_bad,
   input wire logic fault_in_handler_call,
   input wire logic dispatch_structure_bad,
   input wire logic ipmsg_structure_bad,
   input wire logic fault_ack,
   input wire logic fault_valid,
   input wire logic [7:0] fault_type,
   input wire logic [7:0] fault_subtype,
   input wire logic [31:0] fault_data0,
   input wire logic [31:0] fault_data1,
   input wire logic [31:0] saved_ip,
   input wire logic instr_abort,
   input wire logic state_undefined
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Idle unit with no control or handler-call fault pending
   sequence s_free;
      !fault_valid && !ctrl_structure_bad && !fault_in_handler_call;
   endsequence
   // Protection check that nothing structural outranks
   sequence s_prot;
      s_free ##0 !dispatch_structure_bad && !ipmsg_structure_bad && check_valid;
   endsequence
   chk_page_taken: assert property (s_prot ##0 page_rights_denied |=>
      fault_valid && fault_type == 8'h07 && fault_subtype[2]) else $error("page fault lost");
   chk_seg_taken: assert property (s_prot ##0 (operand_out_of_bounds || selector_too_large)
      |=> fault_subtype[1]) else $error("segment length bit missing");
   chk_seg_clear: assert property (s_prot ##0 page_rights_denied && !operand_out_of_bounds
      && !selector_too_large
      |=> !fault_subtype[1]) else $error("segment length bit spurious");
   chk_dispatch_code: assert property (s_free ##0 dispatch_structure_bad |=>
      fault_type == 8'h09 && fault_subtype == 8'h02) else $error("dispatch code wrong");
   chk_resv_zero: assert property (fault_valid && fault_type == 8'h07 |->
      fault_subtype[7:3] == 5'h0 && !fault_subtype[0]) else $error("reserved subtype bit set");
   chk_top_zero: assert property (fault_valid && fault_type == 8'h07 |->
      fault_data0[31:30] == 2'b00) else $error("address top bits not cleared");
   chk_struct_unused: assert property (fault_valid && fault_type == 8'h09 |->
      fault_data0 == 0 && fault_data1 == 0 && saved_ip == 0) else $error("structural data used");
   chk_struct_undef: assert property ($rose(fault_valid) && fault_type == 8'h09 |->
      state_undefined && instr_abort) else $error("structural state not undefined");
   chk_hold_record: assert property (fault_valid && !fault_ack |=> fault_valid &&
      $stable(fault_type) && $stable(fault_data0)) else $error("record changed before ack");
endmodule // protection_structural_fault_unit_sva
bind protection_structural_fault_unit
   protection_structural_fault_unit_sva i_protection_structural_fault_unit_sva (.*);
`default_nettype wire

// ---- sim/protection_structural_fault_unit_tb_top.sv ----
/*
 Self-checking testbench for the protection and structural fault unit.
 Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module protection_structural_fault_unit_tb_top;
   logic clk, reset, check_valid, operand_out_of_bounds, selector_too_large, page_rights_denied;
   logic access_write, implicit_op, ctrl_structure_bad, fault_in_handler_call, fault_ack;
   logic dispatch_structure_bad, ipmsg_structure_bad, suspendable_instr, fault_valid;
   logic write_access_flag, second_fault_flag, instr_abort, instr_suspend, resumable;
   logic state_undefined;
   logic [7:0] fault_type, fault_subtype;
   logic [26:0] region_selector, used_selector;
   logic [31:0] fault_address, instr_ip, partial_state, fault_data0, fault_data1;
   logic [31:0] faulting_ip, saved_ip, resumption_state;
   int fail_count = 0;
   int samples_checked = 0;
   protection_structural_fault_unit i_protection_structural_fault_unit (.*);
   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task step;
      @(posedge clk);
      #10;
   endtask
   task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, exp, seen);
      end
   endtask
   // Drops every fault condition
   task clr;
      {check_valid, operand_out_of_bounds, selector_too_large, page_rights_denied} = '0;
      {implicit_op, ctrl_structure_bad, fault_in_handler_call} = '0;
      {dispatch_structure_bad, ipmsg_structure_bad} = '0;
   endtask
   task take(input logic [7:0] t, input logic [7:0] s);
      step;
      clr;
      chk("valid", fault_valid, 1);
      chk("type", fault_type, t);
      chk("subtype", fault_subtype, s);
   endtask
   task ack;
      fault_ack = 1'b1;
      step;
      fault_ack = 1'b0;
      chk("cleared", fault_valid, 0);
   endtask
   task prot(input logic oob, sel, pg, wr, input logic [7:0] sub);
      check_valid = 1'b1;
      {operand_out_of_bounds, selector_too_large, page_rights_denied} = {oob, sel, pg};
      access_write = wr;
      suspendable_instr = wr;
      take(8'h07, sub);
      chk("ip", faulting_ip, instr_ip);
      chk("saved", saved_ip, instr_ip);
      if (pg) chk("wflag", write_access_flag, wr);
      chk("f1", second_fault_flag, 0);
      chk("resume", resumable, 1);
      chk("susp", instr_suspend, wr);
      chk("abort", instr_abort, !wr);
      chk("rstate", resumption_state, wr ? partial_state : 32'h0000_0000);
      if (sel & !oob & !pg) begin
         chk("sel", fault_data1[31:5], used_selector);
         chk("page0", fault_data0, 0);
      end else begin
         chk("page", fault_data0[31:12], {2'b00, fault_address[29:12]});
         chk("region", fault_data1[31:5], region_selector);
      end
      ack;
   endtask
   // Every structural code, outranking a pending page fault
   task structural;
      for (int k = 0; k < 4; k++) begin
         ctrl_structure_bad = (k == 0);
         fault_in_handler_call = (k == 1);
         dispatch_structure_bad = !k[0]; // Also pending under control in pass 0
         ipmsg_structure_bad = k[0];
         implicit_op = k[0];
         check_valid = 1'b1;
         page_rights_denied = 1'b1;
         take(8'h09, (k < 2) ? 8'h01 : k[7:0]);
         chk("sip", faulting_ip, k[0] ? 32'h0 : instr_ip);
         chk("sdata", fault_data0 | fault_data1 | saved_ip, 0);
         chk("sflag", write_access_flag, 0);
         chk("undef", state_undefined, 1);
         chk("sresume", {instr_suspend, resumable}, 0);
         ack;
      end
   endtask
   task refused;
      check_valid = 1'b1;
      page_rights_denied = 1'b1;
      take(8'h07, 8'h04);
      dispatch_structure_bad = 1'b1;
      step;
      clr;
      chk("held", fault_type, 8'h07);
      ack;
      page_rights_denied = 1'b1;
      step;
      clr;
      chk("gated", fault_valid, 0);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200_000;
      fail_count++;
      end_sim;
   end
   // Reset, then every scenario
   initial begin
      clr;
      {access_write, suspendable_instr, fault_ack} = '0;
      fault_address = 32'hFEDC_B987;
      region_selector = 27'h123_4567;
      used_selector = 27'h765_4321;
      instr_ip = 32'h0000_1A2C;
      partial_state = 32'hCAFE_0001;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #10;
      chk("rst", fault_valid, 0);
      reset = 1'b0;
      step;
      prot(0, 0, 1, 1, 8'h04);
      prot(0, 0, 1, 0, 8'h04);
      prot(1, 0, 0, 0, 8'h02);
      prot(0, 1, 0, 1, 8'h02);
      prot(1, 0, 1, 1, 8'h06);
      prot(0, 1, 1, 0, 8'h06);
      structural;
      refused;
      end_sim;
   end
endmodule // protection_structural_fault_unit_tb_top
`default_nettype wire
